// file: rtl/alu_consts.vh
// Purpose: constants for the accumulator / file-register datapath
// Assumes: 14-bit instruction words, 8-bit data, 7-bit register index
// Notes:   included by the datapath top file
// Behaviour
// - literal add updates accumulator and three flags
// - literal and updates accumulator, null flag only
// - target select zero accumulator, one register
// - register and with accumulator, null flag only
// - register add to target, three flags
// - clear one register bit, flags kept
// - set one register bit, flags kept
// - skip when tested bit one, or zero for the clear test, two cycles
// - zero register and set null flag
// - bit group decoded by two opcode bits
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH

// top two bits of the instruction word select the group
`define GRP_MSB        13
`define GRP_LSB        12
`define GRP_BYTE       2'h0
`define GRP_BIT        2'h1
`define GRP_LIT        2'h3
// byte group opcode field
`define BOP_MSB        11
`define BOP_LSB        8
`define BOP_ADD        4'h7
`define BOP_AND        4'h5
`define BOP_CLR        4'h1
// bit group opcode field
`define BITOP_MSB      11
`define BITOP_LSB      10
`define BITOP_CLR      2'h0
`define BITOP_SET      2'h1
`define BITOP_TSTC     2'h2
`define BITOP_TSTS     2'h3
// literal group opcode field, bit 8 is a don't-care for add
`define LOP_MSB        11
`define LOP_LSB        9
`define LOP_ADD        3'h7
`define LOP_AND_MSB    11
`define LOP_AND        4'h9
// operand fields
`define DEST_BIT       7
`define SLOT_MSB       9
`define SLOT_LSB       7
`define IDX_MSB        6
`define IDX_LSB        0
`define LIT_MSB        7
`define LIT_LSB        0
// reset values
`define ACC_RST        8'h00
`define FLAG_RST       1'b0

`endif

// file: rtl/alu_core.v
// Purpose: 8-bit add/and unit with carry, nibble carry and null result
// Assumes: operands valid in the same cycle, purely combinational
// Notes:   leaf of the instruction datapath
`timescale 1ns/10ps
module alu_core #(
  parameter WIDTH = 8
) (
  input  wire [WIDTH-1:0] op_a,
  input  wire [WIDTH-1:0] op_b,
  input  wire             do_and,
  output reg  [WIDTH-1:0] result,
  output reg              carry_out,
  output reg              nibble_out,
  output wire             is_null
);

  wire [WIDTH:0] sum_full;  // sum with carry slot
  wire [4:0]     low_sum;   // low nibble sum with its carry

  assign sum_full = {1'b0, op_a} + {1'b0, op_b};
  assign low_sum  = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};

  ////////////////////////////////////////////////////////////////////////////
  // select logical or arithmetic result
  always @* begin
    if (do_and) begin
      result     = op_a & op_b;
      carry_out  = 1'b0;
      nibble_out = 1'b0;
    end else begin
      result     = sum_full[WIDTH-1:0];
      carry_out  = sum_full[WIDTH];
      nibble_out = low_sum[4];
    end
  end

  // null result detect, all zero bits
  assign is_null = (result == {WIDTH{1'b0}});

endmodule

// file: rtl/alu_instruction_subset.v
// Purpose: executes the add, and, bit and clear subset on one word
// Assumes: one instruction per ref_clk; register file read is comb
// Notes:   file writes are a one-cycle strobe with data and index
`timescale 1ns/10ps
`include "alu_consts.vh"
module alu_instruction_subset #(
  parameter DW = 8,
  parameter IW = 7
) (
  input  wire          ref_clk,
  input  wire          rst,
  input  wire          instr_valid,
  input  wire [13:0]   instr_word,
  output wire [IW-1:0] file_index,
  input  wire [DW-1:0] file_rdata,
  output reg           file_we_q,
  output reg  [IW-1:0] file_waddr_q,
  output reg  [DW-1:0] file_wdata_q,
  output reg  [DW-1:0] acc_q,
  output reg           adder_overflow_bit_q,
  output reg           nibble_overflow_bit_q,
  output reg           result_null_bit_q,
  output reg           idle_cycle_q,
  output wire          instr_taken,
  output reg           unknown_op_q
);

  ////////////////////////////////////////////////////////////////////////////
  // field split
  // every field is cut unconditionally; the decode decides which apply
  wire [1:0]    grp;       // instruction group
  wire [3:0]    bop;       // byte-op code
  wire [1:0]    bitop;     // bit-op code
  wire [2:0]    slot;      // bit position
  wire          tgt;       // target select
  wire [DW-1:0] lit;       // literal value
  wire [DW-1:0] bit_mask;  // one-hot of slot

  assign grp        = instr_word[`GRP_MSB:`GRP_LSB];
  assign bop        = instr_word[`BOP_MSB:`BOP_LSB];
  assign bitop      = instr_word[`BITOP_MSB:`BITOP_LSB];
  assign slot       = instr_word[`SLOT_MSB:`SLOT_LSB];
  assign tgt        = instr_word[`DEST_BIT];
  assign lit        = instr_word[`LIT_MSB:`LIT_LSB];
  assign file_index = instr_word[`IDX_MSB:`IDX_LSB];

  // one-hot mask from a 3-bit slot, shared by set, clear and test
  function [DW-1:0] slot_mask;
    input [2:0] s;
    begin
      slot_mask = {{(DW-1){1'b0}}, 1'b1} << s;
    end
  endfunction

  assign bit_mask = slot_mask(slot);

  // no new word is accepted while a skipped slot is being idled
  assign instr_taken = instr_valid & ~idle_cycle_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire is_add_literal_to_accumulator;  // literal add
  wire is_and_literal_into_accumulator;  // literal and
  wire is_add_accumulator_to_register;  // register add
  wire is_and_accumulator_with_register;  // register and
  wire is_zero_register;   // zero register
  wire is_bit;    // bit group

  // literal and needs all four code bits, literal add only the top three
  assign is_add_literal_to_accumulator = (grp == `GRP_LIT) &&
                    (instr_word[`LOP_MSB:`LOP_LSB] == `LOP_ADD);
  assign is_and_literal_into_accumulator = (grp == `GRP_LIT) && (bop == `LOP_AND);
  assign is_add_accumulator_to_register = (grp == `GRP_BYTE) && (bop == `BOP_ADD);
  assign is_and_accumulator_with_register = (grp == `GRP_BYTE) && (bop == `BOP_AND);
  // target zero would clear the accumulator; that form is left out
  assign is_zero_register  = (grp == `GRP_BYTE) && (bop == `BOP_CLR) && tgt;
  assign is_bit   = (grp == `GRP_BIT);

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic unit; second operand is literal or file register
  wire [DW-1:0] alu_res;   // add or and result
  wire          alu_c;     // carry
  wire          alu_dc;    // nibble carry
  wire          alu_z;     // null result
  wire          use_lit;   // literal operand form
  wire [DW-1:0] op_b_sel;  // literal or register operand

  assign use_lit  = is_add_literal_to_accumulator | is_and_literal_into_accumulator;
  // the register read runs even for literal words; the mux keeps a
  // stray register value from ever reaching the literal forms
  assign op_b_sel = use_lit ? lit : file_rdata;

  // carries of the and form are simply not copied to the flags
  alu_core #(
    .WIDTH (DW)
  ) u_alu_core (
    .op_a       (acc_q),
    .op_b       (op_b_sel),
    .do_and     (is_and_literal_into_accumulator | is_and_accumulator_with_register),
    .result     (alu_res),
    .carry_out  (alu_c),
    .nibble_out (alu_dc),
    .is_null    (alu_z)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for accumulator, flags and file write
  reg [DW-1:0] acc_d;     // next accumulator
  reg          c_d;       // next carry flag
  reg          dc_d;      // next nibble flag
  reg          z_d;       // next null flag
  reg          we_d;      // file write strobe
  reg [DW-1:0] wdata_d;   // file write data
  reg          skip_d;    // next slot is idled
  reg          unk_d;     // word outside the subset

  // defaults hold accumulator, flags and write data, so an idled slot or a word outside
  // the subset leaves the visible state exactly as it was; write data
  // is held rather than zeroed so the write bus stays quiet between
  // strobes, at the price of a stale value beside a low strobe
  always @* begin
    acc_d   = acc_q;
    c_d     = adder_overflow_bit_q;
    dc_d    = nibble_overflow_bit_q;
    z_d     = result_null_bit_q;
    we_d    = 1'b0;
    wdata_d = file_wdata_q;
    skip_d  = 1'b0;
    unk_d   = 1'b0;
    if (instr_taken) begin
      if (is_add_literal_to_accumulator) begin
        // literal add, all three flags
        acc_d = alu_res;
        c_d   = alu_c;
        dc_d  = alu_dc;
        z_d   = alu_z;
      end else if (is_and_literal_into_accumulator) begin
        // literal and, carries untouched
        acc_d = alu_res;
        z_d   = alu_z;
      end else if (is_add_accumulator_to_register || is_and_accumulator_with_register) begin
        // register form, target picks destination
        if (tgt) begin
          // target one: result goes back to the register
          we_d    = 1'b1;
          wdata_d = alu_res;
        end else begin
          // target zero: result replaces the accumulator
          acc_d = alu_res;
        end
        z_d = alu_z;
        // only the add form moves the two carry flags
        if (is_add_accumulator_to_register) begin
          c_d  = alu_c;
          dc_d = alu_dc;
        end
      end else if (is_zero_register) begin
        // zero register, null flag forced
        we_d    = 1'b1;
        wdata_d = {DW{1'b0}};
        z_d     = 1'b1;
      end else if (is_bit) begin
        // bit group, flags never touched
        case (bitop)
          `BITOP_CLR: begin
            // read-modify-write, one bit forced low
            we_d    = 1'b1;
            wdata_d = file_rdata & ~bit_mask;
          end
          `BITOP_SET: begin
            // read-modify-write, one bit forced high
            we_d    = 1'b1;
            wdata_d = file_rdata | bit_mask;
          end
          `BITOP_TSTC: begin
            // idle the next slot when the bit reads low
            skip_d = ~|(file_rdata & bit_mask);
          end
          `BITOP_TSTS: begin
            // idle the next slot when the bit reads high
            skip_d = |(file_rdata & bit_mask);
          end
          default: begin
            // unreachable with a two-bit code, kept for safety
            skip_d = 1'b0;
          end
        endcase
      end else begin
        // outside the subset; state kept, flagged for the sequencer
        unk_d = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  // the write address follows the word every cycle; only the strobe
  // qualifies it, so the register file must ignore it while low
  // reset loads constants only, nothing is read from other registers
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_q                 <= `ACC_RST;
      adder_overflow_bit_q  <= `FLAG_RST;
      nibble_overflow_bit_q <= `FLAG_RST;
      result_null_bit_q     <= `FLAG_RST;
      file_we_q             <= 1'b0;
      file_waddr_q          <= {IW{1'b0}};
      file_wdata_q          <= {DW{1'b0}};
      idle_cycle_q          <= 1'b0;
      unknown_op_q          <= 1'b0;
    end else begin
      acc_q                 <= acc_d;
      adder_overflow_bit_q  <= c_d;
      nibble_overflow_bit_q <= dc_d;
      result_null_bit_q     <= z_d;
      file_we_q             <= we_d;
      file_waddr_q          <= file_index;
      file_wdata_q          <= wdata_d;
      idle_cycle_q          <= skip_d;
      unknown_op_q          <= unk_d;
    end
  end

endmodule

// file: dv/alu_instruction_subset_sva.sv
// Purpose: property checker for the instruction datapath
// Assumes: bound to the top module, one clock domain
// Notes:   register file reads are combinational, same cycle
`timescale 1ns/10ps
module alu_instruction_subset_sva #(
  parameter DW = 8,
  parameter IW = 7
) (
  input wire          ref_clk,
  input wire          rst,
  input wire [13:0]   instr_word,
  input wire [DW-1:0] file_rdata,
  input wire          file_we_q,
  input wire [IW-1:0] file_waddr_q,
  input wire [DW-1:0] file_wdata_q,
  input wire [DW-1:0] acc_q,
  input wire          adder_overflow_bit_q,
  input wire          nibble_overflow_bit_q,
  input wire          result_null_bit_q,
  input wire          idle_cycle_q,
  input wire          instr_taken
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  // decode of the word taken this cycle
  wire [5:0] op      = instr_word[13:8];
  wire       lit_add = instr_taken && op[5:1] == 5'h1f;
  wire       lit_and = instr_taken && op == 6'h39;
  wire       reg_add = instr_taken && op == 6'h07;
  wire       reg_and = instr_taken && op == 6'h05;
  wire       zero_rg = instr_taken && op == 6'h01 && instr_word[7];
  wire       bit_wr  = instr_taken && op[5:3] == 3'h2;
  wire       skip_1  = instr_taken && op[5:2] == 4'h7;
  wire       to_file = instr_word[7];
  wire [7:0] mask    = 8'h01 << instr_word[9:7];
  wire       tested  = |(file_rdata & mask);
  // nine-bit sums keep the carry out of bit 7
  wire [8:0] rsum    = {1'b0, acc_q} + {1'b0, file_rdata};
  wire [8:0] lsum    = {1'b0, acc_q} + {1'b0, instr_word[7:0]};
  wire [4:0] lnib    = {1'b0, acc_q[3:0]} + {1'b0, instr_word[3:0]};
  wire [4:0] rnib    = {1'b0, acc_q[3:0]} + {1'b0, file_rdata[3:0]};
  wire [2:0] flags   = {adder_overflow_bit_q, nibble_overflow_bit_q,
                        result_null_bit_q};
  // a taken skip idles exactly one slot
  sequence s_one_idle;
    idle_cycle_q ##1 !idle_cycle_q;
  endsequence
  ////////////////////////////////////////////////////////////////////
  a_lit_add_sum: assert property (lit_add |=>
    {adder_overflow_bit_q, acc_q} == $past(lsum)
    && nibble_overflow_bit_q == $past(lnib[4]))
    else $error("literal add result or carry wrong");
  a_lit_and_keep: assert property (lit_and |=>
    acc_q == $past(acc_q & instr_word[7:0]) && $stable(flags[2:1]))
    else $error("literal and result or flags wrong");
  a_null_match: assert property ((lit_add || lit_and
    || ((reg_add || reg_and) && !to_file))
    |=> result_null_bit_q == (acc_q == 8'h00))
    else $error("null flag does not follow result");
  a_add_to_acc: assert property (reg_add && !to_file |=>
    {adder_overflow_bit_q, acc_q} == $past(rsum) && !file_we_q
    && nibble_overflow_bit_q == $past(rnib[4]))
    else $error("register add into accumulator wrong");
  a_add_to_reg: assert property (reg_add && to_file |=>
    file_we_q && file_wdata_q == $past(rsum[7:0]) && $stable(acc_q)
    && file_waddr_q == $past(instr_word[6:0])
    && adder_overflow_bit_q == $past(rsum[8])
    && nibble_overflow_bit_q == $past(rnib[4])
    && result_null_bit_q == (file_wdata_q == 8'h00))
    else $error("register add into file wrong");
  a_and_reg_flag: assert property (reg_and |=>
    $stable(flags[2:1])
    && result_null_bit_q == ($past(acc_q & file_rdata) == 8'h00)
    && ($past(to_file) ? file_wdata_q : acc_q) == $past(acc_q & file_rdata))
    else $error("register and wrong");
  a_bit_write: assert property (bit_wr |=>
    file_we_q && $stable(flags) && file_wdata_q ==
    $past(instr_word[10] ? file_rdata | mask : file_rdata & ~mask))
    else $error("single bit write wrong");
  a_skip_gap: assert property (skip_1 && tested |=> s_one_idle)
    else $error("taken skip did not idle one slot");
  a_no_skip: assert property (skip_1 && !tested |=> !idle_cycle_q)
    else $error("skip taken on a clear bit");
  a_idle_inert: assert property (idle_cycle_q |-> !instr_taken
    ##1 (!file_we_q && $stable(acc_q)))
    else $error("idled slot had an effect");
  a_zero_reg: assert property (zero_rg |=>
    file_we_q && file_wdata_q == 8'h00 && result_null_bit_q)
    else $error("register zeroing wrong");
endmodule
bind alu_instruction_subset alu_instruction_subset_sva #(
  .DW (DW),
  .IW (IW)
) u_sva (
  .ref_clk               (ref_clk),
  .rst                   (rst),
  .instr_word            (instr_word),
  .file_rdata            (file_rdata),
  .file_we_q             (file_we_q),
  .file_waddr_q          (file_waddr_q),
  .file_wdata_q          (file_wdata_q),
  .acc_q                 (acc_q),
  .adder_overflow_bit_q  (adder_overflow_bit_q),
  .nibble_overflow_bit_q (nibble_overflow_bit_q),
  .result_null_bit_q     (result_null_bit_q),
  .idle_cycle_q          (idle_cycle_q),
  .instr_taken           (instr_taken)
);

// file: dv/alu_instruction_subset_tb.sv
// Purpose: directed bench for the instruction datapath
// Assumes: register file model with write-through on reads
// Notes:   words are offered at rising edges, back to back
`timescale 1ns/10ps
module alu_instruction_subset_tb;
  reg         ref_clk     = 1'b0;
  reg         rst         = 1'b1;
  reg         instr_valid = 1'b0;
  reg  [13:0] instr_word  = 14'h0000;
  reg  [7:0]  mem [0:127];           // register file contents
  reg  [7:0]  exp_acc;               // running accumulator model
  integer     num_errors  = 0;
  integer     checks_done = 0;
  integer     i;
  wire [6:0]  file_index, file_waddr_q;
  wire [7:0]  file_rdata, file_wdata_q, acc_q;
  wire        file_we_q, idle_cycle_q, instr_taken, unknown_op_q;
  wire        adder_overflow_bit_q, nibble_overflow_bit_q;
  wire        result_null_bit_q;
  // flags above accumulator, compared as one value
  wire [10:0] state = {adder_overflow_bit_q, nibble_overflow_bit_q,
                       result_null_bit_q, acc_q};
  alu_instruction_subset u_alu_instruction_subset (
    .ref_clk               (ref_clk),
    .rst                   (rst),
    .instr_valid           (instr_valid),
    .instr_word            (instr_word),
    .file_index            (file_index),
    .file_rdata            (file_rdata),
    .file_we_q             (file_we_q),
    .file_waddr_q          (file_waddr_q),
    .file_wdata_q          (file_wdata_q),
    .acc_q                 (acc_q),
    .adder_overflow_bit_q  (adder_overflow_bit_q),
    .nibble_overflow_bit_q (nibble_overflow_bit_q),
    .result_null_bit_q     (result_null_bit_q),
    .idle_cycle_q          (idle_cycle_q),
    .instr_taken           (instr_taken),
    .unknown_op_q          (unknown_op_q)
  );
  ////////////////////////////////////////////////////////////////////
  // pending write wins so back-to-back reads see it
  assign file_rdata = (file_we_q && file_waddr_q == file_index) ?
                      file_wdata_q : mem[file_index];
  always @(posedge ref_clk) begin
    if (file_we_q)
      mem[file_waddr_q] <= file_wdata_q;
  end
  always #25 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////
  // offer a word; it is taken at the following edge
  task op(input [13:0] w);
    begin
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      instr_word  <= w;
    end
  endtask
  // let the last word land, then look just after the edge
  task settle;
    begin
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      #1;
    end
  endtask
  task chk(input string nm, input [10:0] exp, input [10:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // skip test, then an add of 1, refused only when skipped, and a taken add of 2
  task try_skip(input [13:0] w, input skipped);
    begin
      op(w);
      op(14'h3e01);
      #1;
      chk("idle", {9'h000, skipped, ~skipped},
          {9'h000, idle_cycle_q, instr_taken});
      op(14'h3e02);
      settle;
      exp_acc = exp_acc + (skipped ? 8'h02 : 8'h03);
      chk("acc", {3'h0, exp_acc}, {3'h0, acc_q});
    end
  endtask
  task end_of_test;
    begin
      if (num_errors == 0 && checks_done > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    for (i = 0; i < 128; i = i + 1)
      mem[i] = 8'h00;
    mem[5] = 8'hf0;
    mem[6] = 8'h10;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    // both carries out of one add
    op(14'h3ef8);
    op(14'h3f0c);
    settle;
    chk("add_lit", 11'h604, state);
    // ands keep both carries, null goes high
    op(14'h393c);
    op(14'h3903);
    settle;
    chk("and_lit", 11'h700, state);
    // register add and and, to file and to accumulator
    op(14'h3e1f);
    op(14'h0785);
    op(14'h0705);
    op(14'h0505);
    op(14'h0586);
    settle;
    settle;
    chk("reg_ops", 11'h30e, state);
    chk("mem5", 11'h00f, {3'h0, mem[5]});
    chk("mem6", 11'h000, {3'h0, mem[6]});
    // set two bits, clear one, flags untouched
    op(14'h1789);
    op(14'h1409);
    op(14'h1389);
    settle;
    settle;
    chk("bits", 11'h001, {3'h0, mem[9]});
    chk("bit_flags", 11'h30e, state);
    exp_acc = 8'h0e;
    try_skip(14'h1c09, 1'b1);
    try_skip(14'h1c89, 1'b0);
    try_skip(14'h1889, 1'b1);
    op(14'h0189);
    settle;
    settle;
    chk("zero_reg", 11'h115, state);
    chk("mem9", 11'h000, {3'h0, mem[9]});
    // a neighbouring literal code is flagged and changes nothing
    op(14'h3800);
    settle;
    chk("unknown", 11'h001, {10'h000, unknown_op_q});
    chk("unk_state", 11'h115, state);
    end_of_test;
  end
  // hang guard, far beyond the few dozen cycles of the run
  initial begin
    #20000;
    num_errors = num_errors + 1;
    end_of_test;
  end
endmodule
